// *** design/mvrb_bank.sv ***
// Functional notes
// - aux five register written 0Dh, read 8Dh
// - mute at D5, five-bit gain D4..D0
// - mixer gain +12 dB minus 1.5 dB/step
// - mute set silences path whatever the gain
// - microphone register written 0Eh, read 8Eh
// - aux six gain D4..D1, D0 zero
// - aux six gain 0 dB minus 3 dB/step
// - aux six and masters reset to 60h
// - aux five, mic, converter mixers reset 68h
// - converter mixer pair at 10h/11h, read +80h
// - line out master pair at 12h/13h
// - master gain 0 dB minus 1.5 dB/step
// - converter master pair at 14h/15h
// - mono master written 16h, read 96h
// - left and right stored independently
`timescale 1ns/100ps
`include "mvrb_consts.svh"
module mvrb_bank (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // axi4-lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    // axi4-lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    // axi4-lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // mixer input paths
    output logic             aux_five_mute,
    output mvrb_pkg::mvrb_hdb_t aux_five_gain_hdb,
    output logic             microphone_mute,
    output mvrb_pkg::mvrb_hdb_t microphone_gain_hdb,
    output logic             aux_six_mute,
    output mvrb_pkg::mvrb_hdb_t aux_six_gain_hdb,
    output logic             converter_left_mixer_mute,
    output mvrb_pkg::mvrb_hdb_t converter_left_mixer_gain_hdb,
    output logic             converter_right_mixer_mute,
    output mvrb_pkg::mvrb_hdb_t converter_right_mixer_gain_hdb,
    // master paths
    output logic             line_out_left_mute,
    output mvrb_pkg::mvrb_hdb_t line_out_left_gain_hdb,
    output logic             line_out_right_mute,
    output mvrb_pkg::mvrb_hdb_t line_out_right_gain_hdb,
    output logic             converter_left_master_mute,
    output mvrb_pkg::mvrb_hdb_t converter_left_master_gain_hdb,
    output logic             converter_right_master_mute,
    output mvrb_pkg::mvrb_hdb_t converter_right_master_gain_hdb,
    output logic             single_channel_master_mute,
    output mvrb_pkg::mvrb_hdb_t single_channel_master_gain_hdb
);
    import mvrb_pkg::*;

    // slot = register index minus the first write index
    function automatic mvrb_law_e slot_law(input int i);
        mvrb_byte_t idx;
        idx = `MVRB_WR_BASE + 8'(i);
        if (idx == `MVRB_IDX_AUX6) begin
            slot_law = MVRB_LAW_AUX6;
        end else if (idx >= `MVRB_IDX_OUT_L) begin
            slot_law = MVRB_LAW_MASTER;
        end else begin
            slot_law = MVRB_LAW_MIX;
        end
    endfunction : slot_law

    function automatic mvrb_byte_t slot_rst(input int i);
        slot_rst = (slot_law(i) == MVRB_LAW_MIX) ? `MVRB_RST_MIX : `MVRB_RST_MASTER;
    endfunction : slot_rst

    function automatic mvrb_byte_t slot_mask(input int i);
        slot_mask = (slot_law(i) == MVRB_LAW_AUX6) ? `MVRB_MASK_AUX6 : `MVRB_MASK_FULL;
    endfunction : slot_mask

    // {hit, slot} for a byte address against a window base
    function automatic logic [4:0] slot_of(input logic [31:0] a, input mvrb_byte_t base);
        mvrb_byte_t d;
        d = a[9:2] - base;
        slot_of = {(a[31:10] == 22'h0) && (a[1:0] == 2'h0) && (a[9:2] >= base)
                   && (d < 8'(`MVRB_NREG)), d[3:0]};
    endfunction : slot_of

    mvrb_byte_t reg_q [`MVRB_NREG];
    logic       mute_w [`MVRB_NREG];
    mvrb_hdb_t  gain_w [`MVRB_NREG];

    // write channel state
    mvrb_wr_e    wr_state_ff;
    logic        awready_ff;
    logic        wready_ff;
    logic        aw_got_ff;
    logic        w_got_ff;
    logic [31:0] awaddr_ff;
    mvrb_byte_t  wdata_ff;
    logic        wstrb0_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        wr_en_ff;
    logic [3:0]  wr_slot_ff;
    mvrb_byte_t  wr_data_ff;
    logic [4:0]  wr_hit;

    // read channel state
    mvrb_rd_e    rd_state_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic [4:0]  rd_hit;

    assign wr_hit = slot_of(awaddr_ff, `MVRB_WR_BASE);
    assign rd_hit = slot_of(s_axi_araddr, `MVRB_RD_OFS + `MVRB_WR_BASE);

    // address and data are taken in either order, each held until the response
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            awready_ff <= 1'b1;
            aw_got_ff  <= 1'b0;
            awaddr_ff  <= 32'h0;
        end else if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_got_ff  <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
        end else if (bvalid_ff && s_axi_bready) begin
            awready_ff <= 1'b1;
            aw_got_ff  <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wready_ff <= 1'b1;
            w_got_ff  <= 1'b0;
            wdata_ff  <= 8'h00;
            wstrb0_ff <= 1'b0;
        end else if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_got_ff  <= 1'b1;
            wdata_ff  <= s_axi_wdata[7:0];
            wstrb0_ff <= s_axi_wstrb[0];
        end else if (bvalid_ff && s_axi_bready) begin
            wready_ff <= 1'b1;
            w_got_ff  <= 1'b0;
        end
    end

    // one write per response; unmapped or read-window writes get slverr
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_state_ff <= MVRB_WR_IDLE;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= `MVRB_RESP_OKAY;
            wr_en_ff    <= 1'b0;
            wr_slot_ff  <= 4'h0;
            wr_data_ff  <= 8'h00;
        end else begin
            wr_en_ff <= 1'b0;
            unique case (wr_state_ff)
                MVRB_WR_IDLE: begin
                    if (aw_got_ff && w_got_ff) begin
                        wr_en_ff    <= wr_hit[4] && wstrb0_ff;
                        wr_slot_ff  <= wr_hit[3:0];
                        wr_data_ff  <= wdata_ff;
                        bvalid_ff   <= 1'b1;
                        bresp_ff    <= wr_hit[4] ? `MVRB_RESP_OKAY : `MVRB_RESP_SLVERR;
                        wr_state_ff <= MVRB_WR_RESP;
                    end
                end
                MVRB_WR_RESP: begin
                    if (s_axi_bready) begin
                        bvalid_ff   <= 1'b0;
                        wr_state_ff <= MVRB_WR_IDLE;
                    end
                end
            endcase
        end
    end

    // reads answer one cycle after the address is taken
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_state_ff <= MVRB_RD_IDLE;
            arready_ff  <= 1'b1;
            rvalid_ff   <= 1'b0;
            rdata_ff    <= 32'h0;
            rresp_ff    <= `MVRB_RESP_OKAY;
        end else begin
            unique case (rd_state_ff)
                MVRB_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        arready_ff  <= 1'b0;
                        rvalid_ff   <= 1'b1;
                        rdata_ff    <= rd_hit[4] ? {24'h0, reg_q[rd_hit[3:0]]} : 32'h0;
                        rresp_ff    <= rd_hit[4] ? `MVRB_RESP_OKAY : `MVRB_RESP_SLVERR;
                        rd_state_ff <= MVRB_RD_RESP;
                    end
                end
                MVRB_RD_RESP: begin
                    if (s_axi_rready) begin
                        arready_ff  <= 1'b1;
                        rvalid_ff   <= 1'b0;
                        rd_state_ff <= MVRB_RD_IDLE;
                    end
                end
            endcase
        end
    end

    // one register and one applied path per slot, each pair member separate
    for (genvar i = 0; i < `MVRB_NREG; i++) begin : g_slot
        mvrb_reg #(
            .RST_VAL (slot_rst(i)),
            .WR_MASK (slot_mask(i))
        ) u_reg (
            .sys_clk (sys_clk),
            .sys_rst (sys_rst),
            .wr_en   (wr_en_ff && (wr_slot_ff == 4'(i))),
            .wr_data (wr_data_ff),
            .q_ff    (reg_q[i])
        );
        mvrb_path #(
            .LAW (slot_law(i))
        ) u_path (
            .sys_clk     (sys_clk),
            .sys_rst     (sys_rst),
            .reg_val     (reg_q[i]),
            .mute_ff     (mute_w[i]),
            .gain_hdb_ff (gain_w[i])
        );
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    assign aux_five_mute                   = mute_w[0];
    assign aux_five_gain_hdb               = gain_w[0];
    assign microphone_mute                 = mute_w[1];
    assign microphone_gain_hdb             = gain_w[1];
    assign aux_six_mute                    = mute_w[2];
    assign aux_six_gain_hdb                = gain_w[2];
    assign converter_left_mixer_mute       = mute_w[3];
    assign converter_left_mixer_gain_hdb   = gain_w[3];
    assign converter_right_mixer_mute      = mute_w[4];
    assign converter_right_mixer_gain_hdb  = gain_w[4];
    assign line_out_left_mute              = mute_w[5];
    assign line_out_left_gain_hdb          = gain_w[5];
    assign line_out_right_mute             = mute_w[6];
    assign line_out_right_gain_hdb         = gain_w[6];
    assign converter_left_master_mute      = mute_w[7];
    assign converter_left_master_gain_hdb  = gain_w[7];
    assign converter_right_master_mute     = mute_w[8];
    assign converter_right_master_gain_hdb = gain_w[8];
    assign single_channel_master_mute      = mute_w[9];
    assign single_channel_master_gain_hdb  = gain_w[9];

    // checks
    logic any_d7;
    always_comb begin
        any_d7 = 1'b0;
        for (int k = 0; k < `MVRB_NREG; k++) begin
            any_d7 = any_d7 | reg_q[k][7];
        end
    end

    logic ar_take;
    assign ar_take = s_axi_arvalid && arready_ff;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    property p_reset_mix;
        $past(sys_rst) |-> (reg_q[0] == `MVRB_RST_MIX) && (reg_q[1] == `MVRB_RST_MIX)
            && (reg_q[3] == `MVRB_RST_MIX) && (reg_q[4] == `MVRB_RST_MIX);
    endproperty
    a_reset_mix: assert property (p_reset_mix) else $error("mixer reset value wrong");

    property p_reset_master;
        $past(sys_rst) |-> (reg_q[2] == `MVRB_RST_MASTER) && (reg_q[5] == `MVRB_RST_MASTER)
            && (reg_q[9] == `MVRB_RST_MASTER) && aux_six_mute;
    endproperty
    a_reset_master: assert property (p_reset_master) else $error("master reset wrong");

    property p_d7_zero;
        !any_d7;
    endproperty
    a_d7_zero: assert property (p_d7_zero) else $error("bit 7 set");

    property p_aux6_d0;
        reg_q[2][0] == 1'b0;
    endproperty
    a_aux6_d0: assert property (p_aux6_d0) else $error("aux six bit 0 set");

    property p_write_aux5;
        wr_en_ff && (wr_slot_ff == 4'h0) |=> reg_q[0] == ($past(wr_data_ff) & `MVRB_MASK_FULL);
    endproperty
    a_write_aux5: assert property (p_write_aux5) else $error("aux five write lost");

    property p_read_aux5;
        ar_take && (s_axi_araddr == {22'h0, `MVRB_RD_OFS + `MVRB_IDX_AUX5, 2'h0})
            |=> rvalid_ff && (rdata_ff == {24'h0, $past(reg_q[0])});
    endproperty
    a_read_aux5: assert property (p_read_aux5) else $error("aux five read wrong");

    property p_read_conv_mix_r;
        ar_take && (s_axi_araddr == {22'h0, `MVRB_RD_OFS + `MVRB_IDX_CONV_MIX_R, 2'h0})
            |=> rdata_ff[7:0] == $past(reg_q[4]);
    endproperty
    a_read_conv_mix_r: assert property (p_read_conv_mix_r) else $error("mixer read");

    property p_read_conv_mst_r;
        ar_take && (s_axi_araddr == {22'h0, `MVRB_RD_OFS + `MVRB_IDX_CONV_MST_R, 2'h0})
            |=> rdata_ff[7:0] == $past(reg_q[8]);
    endproperty
    a_read_conv_mst_r: assert property (p_read_conv_mst_r) else $error("master read");

    property p_mute_wins;
        reg_q[1][`MVRB_MUTE_BIT] |=> microphone_mute;
    endproperty
    a_mute_wins: assert property (p_mute_wins) else $error("mute not applied");

    property p_mix_unity;
        reg_q[3][4:0] == 5'h08 |=> converter_left_mixer_gain_hdb == 8'sh00;
    endproperty
    a_mix_unity: assert property (p_mix_unity) else $error("mixer 0 dB code");

    property p_aux6_floor;
        reg_q[2][4:1] == 4'hF |=> aux_six_gain_hdb == 8'shA6;
    endproperty
    a_aux6_floor: assert property (p_aux6_floor) else $error("aux six floor");

    property p_mono_floor;
        reg_q[9][4:0] == 5'h1F |=> single_channel_master_gain_hdb == 8'shA3;
    endproperty
    a_mono_floor: assert property (p_mono_floor) else $error("mono floor");

    property p_pair_indep;
        wr_en_ff && (wr_slot_ff == 4'h5) |=> $stable(reg_q[6]);
    endproperty
    a_pair_indep: assert property (p_pair_indep) else $error("right follows left");

    property p_bresp_next;
        (wr_state_ff == MVRB_WR_IDLE) && aw_got_ff && w_got_ff |=> bvalid_ff ##0 !awready_ff;
    endproperty
    a_bresp_next: assert property (p_bresp_next) else $error("write response late");

    c_write: cover property (bvalid_ff && s_axi_bready && (bresp_ff == `MVRB_RESP_OKAY));
    c_read: cover property (rvalid_ff && s_axi_rready && (rresp_ff == `MVRB_RESP_OKAY));
    c_bad_read: cover property (rvalid_ff && (rresp_ff == `MVRB_RESP_SLVERR));
    c_unmute: cover property (!line_out_left_mute && !line_out_right_mute);
endmodule : mvrb_bank

// *** shared/mvrb_consts.svh ***
`ifndef MVRB_CONSTS_SVH
`define MVRB_CONSTS_SVH
`define MVRB_NREG            10
`define MVRB_WR_BASE         8'h0D
`define MVRB_RD_OFS          8'h80
`define MVRB_IDX_AUX5        8'h0D
`define MVRB_IDX_MIC         8'h0E
`define MVRB_IDX_AUX6        8'h0F
`define MVRB_IDX_CONV_MIX_L  8'h10
`define MVRB_IDX_CONV_MIX_R  8'h11
`define MVRB_IDX_OUT_L       8'h12
`define MVRB_IDX_OUT_R       8'h13
`define MVRB_IDX_CONV_MST_L  8'h14
`define MVRB_IDX_CONV_MST_R  8'h15
`define MVRB_IDX_MONO        8'h16
`define MVRB_RST_MIX         8'h68
`define MVRB_RST_MASTER      8'h60
`define MVRB_MASK_FULL       8'h3F
`define MVRB_MASK_AUX6       8'h3E
`define MVRB_MUTE_BIT        5
`define MVRB_MIX_TOP_HDB     8'sh18
`define MVRB_MIX_STEP_HDB    8'sh03
`define MVRB_AUX6_STEP_HDB   8'sh06
`define MVRB_MST_STEP_HDB    8'sh03
`define MVRB_RESP_OKAY       2'h0
`define MVRB_RESP_SLVERR     2'h2
`endif

// *** shared/mvrb_pkg.sv ***
package mvrb_pkg;
    typedef logic [7:0]        mvrb_byte_t;
    typedef logic signed [7:0] mvrb_hdb_t;
    typedef enum logic [1:0] {MVRB_LAW_MIX, MVRB_LAW_AUX6, MVRB_LAW_MASTER} mvrb_law_e;
    typedef enum logic {MVRB_WR_IDLE, MVRB_WR_RESP} mvrb_wr_e;
    typedef enum logic {MVRB_RD_IDLE, MVRB_RD_RESP} mvrb_rd_e;
endpackage : mvrb_pkg

// *** design/mvrb_reg.sv ***
`timescale 1ns/100ps
module mvrb_reg #(
    parameter mvrb_pkg::mvrb_byte_t RST_VAL = 8'h00,
    parameter mvrb_pkg::mvrb_byte_t WR_MASK = 8'hFF
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // write side
    input  wire logic             wr_en,
    input  wire mvrb_pkg::mvrb_byte_t wr_data,
    // stored value
    output mvrb_pkg::mvrb_byte_t  q_ff
);
    import mvrb_pkg::*;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q_ff <= RST_VAL;
        end else if (wr_en) begin
            q_ff <= wr_data & WR_MASK;
        end
    end
endmodule : mvrb_reg

// *** design/mvrb_path.sv ***
`timescale 1ns/100ps
`include "mvrb_consts.svh"
module mvrb_path #(
    parameter mvrb_pkg::mvrb_law_e LAW = mvrb_pkg::MVRB_LAW_MIX
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // register contents
    input  wire mvrb_pkg::mvrb_byte_t reg_val,
    // applied setting
    output logic                  mute_ff,
    output mvrb_pkg::mvrb_hdb_t   gain_hdb_ff
);
    import mvrb_pkg::*;

    // gain in half-dB units
    function automatic mvrb_hdb_t gain_of(input mvrb_byte_t v);
        mvrb_hdb_t c5;
        mvrb_hdb_t c4;
        c5 = {3'h0, v[4:0]};
        c4 = {4'h0, v[4:1]};
        unique case (LAW)
            MVRB_LAW_MIX:    gain_of = `MVRB_MIX_TOP_HDB - `MVRB_MIX_STEP_HDB * c5;
            MVRB_LAW_AUX6:   gain_of = 8'sh00 - `MVRB_AUX6_STEP_HDB * c4;
            MVRB_LAW_MASTER: gain_of = 8'sh00 - `MVRB_MST_STEP_HDB * c5;
        endcase
    endfunction : gain_of

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mute_ff <= 1'b1;
        end else begin
            mute_ff <= reg_val[`MVRB_MUTE_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gain_hdb_ff <= 8'sh00;
        end else begin
            gain_hdb_ff <= gain_of(reg_val);
        end
    end
endmodule : mvrb_path

// *** dv/mvrb_host_model.sv ***
`timescale 1ns/100ps
module mvrb_host_model (
    // clock
    input  wire logic  sys_clk,
    // write channels
    output logic        s_axi_awvalid,
    input  wire logic   s_axi_awready,
    output logic [31:0] s_axi_awaddr,
    output logic        s_axi_wvalid,
    input  wire logic   s_axi_wready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    input  wire logic   s_axi_bvalid,
    output logic        s_axi_bready,
    input  wire logic [1:0] s_axi_bresp,
    // read channels
    output logic        s_axi_arvalid,
    input  wire logic   s_axi_arready,
    output logic [31:0] s_axi_araddr,
    input  wire logic   s_axi_rvalid,
    output logic        s_axi_rready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 32'h0000_0000;
        s_axi_wdata  = 32'h0000_0000;
        s_axi_wstrb  = 4'h0;
        s_axi_araddr = 32'h0000_0000;
    end

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [1:0] resp);
        bit done;
        done = 1'b0;
        @(posedge sys_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_wstrb   <= s;
        s_axi_bready  <= 1'b1;
        while (!done) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
        bit done;
        done = 1'b0;
        @(posedge sys_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        while (!done) begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rd
endmodule : mvrb_host_model

// *** dv/tb_mvrb_bank.sv ***
`timescale 1ns/100ps
`include "mvrb_consts.svh"
module tb_mvrb_bank;
    import mvrb_pkg::*;
    logic        sys_clk, sys_rst;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        mute [10];
    mvrb_hdb_t   gain [10];
    logic [31:0] d, bad;
    mvrb_byte_t  v;
    int          mismatches, total_checks, cycles, i;

    mvrb_host_model i_host (.sys_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

    mvrb_bank i_dut (.sys_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .aux_five_mute(mute[0]), .aux_five_gain_hdb(gain[0]),
        .microphone_mute(mute[1]), .microphone_gain_hdb(gain[1]),
        .aux_six_mute(mute[2]), .aux_six_gain_hdb(gain[2]),
        .converter_left_mixer_mute(mute[3]), .converter_left_mixer_gain_hdb(gain[3]),
        .converter_right_mixer_mute(mute[4]), .converter_right_mixer_gain_hdb(gain[4]),
        .line_out_left_mute(mute[5]), .line_out_left_gain_hdb(gain[5]),
        .line_out_right_mute(mute[6]), .line_out_right_gain_hdb(gain[6]),
        .converter_left_master_mute(mute[7]), .converter_left_master_gain_hdb(gain[7]),
        .converter_right_master_mute(mute[8]), .converter_right_master_gain_hdb(gain[8]),
        .single_channel_master_mute(mute[9]), .single_channel_master_gain_hdb(gain[9]));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] wa(int k);
        return 32'(4 * (`MVRB_WR_BASE + k));
    endfunction : wa

    function automatic logic [31:0] ra(int k);
        return 32'(4 * (`MVRB_WR_BASE + `MVRB_RD_OFS + k));
    endfunction : ra

    // stored image of a written byte: D7 and D6 dropped, aux six D0 dropped
    function automatic mvrb_byte_t kept(int k, mvrb_byte_t x);
        return x & ((k == 2) ? 8'h3E : 8'h3F);
    endfunction : kept

    // applied gain in half-dB steps for the register's law
    function automatic mvrb_hdb_t law(int k, mvrb_byte_t x);
        int g;
        if (k == 2) g = -6 * int'(x[4:1]);
        else if (k >= 5) g = -3 * int'(x[4:0]);
        else g = 24 - 3 * int'(x[4:0]);
        return mvrb_hdb_t'(g);
    endfunction : law

    task automatic report(logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : report

    task automatic chk_data(logic [31:0] got, logic [31:0] exp);
        report(got, exp);
    endtask : chk_data

    task automatic chk_resp(logic [1:0] got, logic [1:0] exp);
        report({30'h0, got}, {30'h0, exp});
    endtask : chk_resp

    task automatic chk_path(logic m, mvrb_hdb_t g, logic me, mvrb_hdb_t ge);
        report({23'h0, m, g}, {23'h0, me, ge});
    endtask : chk_path

    task automatic end_sim;
        $display("total_checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic check_reset;
        for (int k = 0; k < 10; k++) begin
            i_host.rd(ra(k), d, r);
            v = (k <= 1 || k == 3 || k == 4) ? `MVRB_RST_MIX : `MVRB_RST_MASTER;
            chk_data(d, {24'h0, v});
            chk_path(mute[k], gain[k], 1'b1, 8'sh00);
        end
    endtask : check_reset

    // value with D7 set and mute clear, distinct gain code per register
    function automatic mvrb_byte_t pattern(int k);
        return 8'h80 | mvrb_byte_t'(3 * k);
    endfunction : pattern

    initial begin
        forever begin
            @(posedge sys_clk);
            cycles++;
            if (cycles > 5000) begin
                mismatches++;
                end_sim();
            end
        end
    end

    initial begin
        sys_rst = 1'b1;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        check_reset();
        for (i = 0; i < 10; i++) begin
            i_host.wr(wa(i), 8'hFF, 4'h1, r);
            chk_resp(r, `MVRB_RESP_OKAY);
        end
        for (i = 0; i < 10; i++) begin
            i_host.rd(ra(i), d, r);
            chk_data(d, {24'h0, kept(i, 8'hFF)});
            chk_path(mute[i], gain[i], 1'b1, law(i, 8'hFF));
        end
        for (i = 0; i < 10; i++) i_host.wr(wa(i), pattern(i), 4'h1, r);
        for (i = 0; i < 10; i++) begin
            i_host.rd(ra(i), d, r);
            chk_data(d, {24'h0, kept(i, pattern(i))});
            chk_path(mute[i], gain[i], 1'b0, law(i, pattern(i)));
        end
        // refused writes leave aux five and the mono master as they were
        for (i = 0; i < 4; i++) begin
            bad = (i == 0) ? 32'h30 : (i == 1) ? 32'h5C : (i == 2) ? ra(0) : wa(0) + 32'h1;
            i_host.wr(bad, 8'h2A, 4'h1, r);
            chk_resp(r, `MVRB_RESP_SLVERR);
        end
        i_host.wr(wa(0), 8'h2A, 4'h0, r);
        chk_resp(r, `MVRB_RESP_OKAY);
        i_host.rd(ra(0), d, r);
        chk_data(d, {24'h0, kept(0, pattern(0))});
        i_host.rd(ra(9), d, r);
        chk_data(d, {24'h0, kept(9, pattern(9))});
        for (i = 0; i < 3; i++) begin
            bad = (i == 0) ? wa(0) : (i == 1) ? 32'h25C : ra(9) + 32'h2;
            i_host.rd(bad, d, r);
            chk_resp(r, `MVRB_RESP_SLVERR);
            chk_data(d, 32'h0);
        end
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        check_reset();
        end_sim();
    end
endmodule : tb_mvrb_bank
